/* File: hw/byte_parity.sv */
// Per-byte parity generator used for write generation and read checking.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/10ps
module byte_parity #(parameter int LANES = 8) (
   parity_if.calc bus
);
   genvar i;
   generate
      for (i = 0; i < LANES; i++) begin : g_lane
         // Odd sense flips the plain xor so the byte plus bit has odd weight
         assign bus.par[i] = (^bus.data[i*8 +: 8]) ^ bus.oddSense;
      end
   endgenerate
endmodule

/* File: hw/sdram_init_and_timing_ctrl.sv */
// Memory controller: power-up sequence, command timing, byte masks and parity.
// Assumes memory data is synchronous to clock; closed-page, burst of one.
`timescale 1ns/10ps
`include "sdram_ctrl_map.svh"
module sdram_init_and_timing_ctrl import sdram_pkg::*; #(
   parameter int INIT_CYC = `SD_INIT_CYC,
   parameter int REF_CYC  = `SD_REF_CYC,
   parameter int DATA_W   = 64
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   reqValid,
   output logic                        reqReady,
   input  wire logic                   reqWrite,
   input  wire logic [`SD_ADDR_W-1:0]  reqAddr,
   input  wire logic [DATA_W-1:0]      reqWdata,
   input  wire logic [DATA_W/8-1:0]    reqMask,
   output logic                        rdValid,
   output logic [DATA_W-1:0]           rdData,
   output logic                        parityErr,
   input  wire logic                   cfgWrite,
   input  wire logic [12:0]            cfgMode,
   input  wire logic                   parityEnable,
   input  wire logic                   paritySense,
   output logic                        initDone,
   output logic [3:0]                  memCsN,
   output logic                        rasN,
   output logic                        casN,
   output logic                        weN,
   output logic [1:0]                  bankSel,
   output logic [12:0]                 memAddr,
   output logic [DATA_W-1:0]           dqOut,
   input  wire logic [DATA_W-1:0]      dqIn,
   output logic                        dqOeN,
   output logic [DATA_W/8-1:0]         byteMask,
   output logic [DATA_W/8-1:0]         parOut,
   input  wire logic [DATA_W/8-1:0]    parIn,
   output logic                        parOeN
);
   localparam int LANES = DATA_W / 8;
   localparam int CL = `SD_CAS_LAT;

   logic                rstMeta_r, rstSync_r;
   state_t              state_r, state_nxt, ret_r, ret_nxt;
   logic [15:0]         waitCnt_r, waitCnt_nxt;
   cmd_t                cmd_r, cmd_nxt;
   logic [3:0]          csN_r, csN_nxt;
   logic [1:0]          ba_r, ba_nxt;
   logic [12:0]         sa_r, sa_nxt;
   logic [1:0]          csIdx_r;
   logic                cfgSeen_r;
   logic [12:0]         cfgMode_r;
   logic [15:0]         refCnt_r;
   logic                refDue_r;
   logic [3:0]          sinceAct_r;
   logic                take;
   logic [`SD_ADDR_W-1:0] addr_r;
   logic                write_r;
   logic [DATA_W-1:0]   wdata_r, dqOut_r, rdData_r;
   logic [LANES-1:0]    mask_r, dqm_r, parOut_r;
   logic                dqOeN_r, rdValid_r, parityErr_r, initDone_r, reqReady_r;
   logic [CL:0]         rdPipe_r;
   logic [1:0]          csSel;

   // Release is synchronised so no flop leaves reset on a ragged edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   assign csSel = addr_r[`SD_CS_LSB +: 2];

   always_comb begin
      state_nxt   = state_r;
      ret_nxt     = ret_r;
      waitCnt_nxt = (waitCnt_r == 16'h0) ? 16'h0 : 16'(waitCnt_r - 16'h1);
      cmd_nxt     = `SD_CMD_NOP;
      csN_nxt     = 4'hf;
      ba_nxt      = 2'h0;
      sa_nxt      = 13'h0;
      take        = 1'b0;
      case (state_r)
         S_INIT: begin
            if (waitCnt_r == 16'h0) state_nxt = S_IPALL;
         end
         S_IPALL: begin
            cmd_nxt = `SD_CMD_PRE;
            csN_nxt = ~(4'h1 << csIdx_r);
            sa_nxt[`SD_ALLBANK_BIT] = 1'b1;
            waitCnt_nxt = 16'(`SD_T_RP - 2);
            ret_nxt = S_IREF;
            state_nxt = S_WAIT;
         end
         S_IREF: begin
            cmd_nxt = `SD_CMD_REF;
            csN_nxt = ~(4'h1 << csIdx_r);
            waitCnt_nxt = 16'(`SD_T_RC - 2);
            ret_nxt = (csIdx_r == 2'h3) ? S_CFG : S_IPALL;
            state_nxt = S_WAIT;
         end
         S_CFG: begin
            if (cfgSeen_r) state_nxt = S_MRS;
         end
         S_MRS: begin
            cmd_nxt = `SD_CMD_MRS;
            csN_nxt = 4'h0;
            sa_nxt = cfgMode_r;
            waitCnt_nxt = 16'(`SD_T_MRD - 2);
            ret_nxt = S_IDLE;
            state_nxt = S_WAIT;
         end
         S_IDLE: begin
            // A request already granted ready beats a refresh that just fell due
            if (reqValid && reqReady_r) begin
               take = 1'b1;
               state_nxt = S_ACT;
            end else if (refDue_r) begin
               state_nxt = S_REF;
            end
         end
         S_REF: begin
            cmd_nxt = `SD_CMD_REF;
            csN_nxt = 4'h0;
            waitCnt_nxt = 16'(`SD_T_RC - 2);
            ret_nxt = S_IDLE;
            state_nxt = S_WAIT;
         end
         S_ACT: begin
            if (sinceAct_r >= 4'(`SD_T_RRD - 1)) begin
               cmd_nxt = `SD_CMD_ACT;
               csN_nxt = ~(4'h1 << csSel);
               ba_nxt = addr_r[`SD_BANK_LSB +: 2];
               sa_nxt = addr_r[`SD_ROW_LSB +: `SD_ROW_W];
               waitCnt_nxt = 16'(`SD_T_RCD - 2);
               ret_nxt = write_r ? S_WR : S_RD;
               state_nxt = S_WAIT;
            end
         end
         S_RD, S_WR: begin
            cmd_nxt = (state_r == S_WR) ? `SD_CMD_WRITE : `SD_CMD_READ;
            csN_nxt = ~(4'h1 << csSel);
            ba_nxt = addr_r[`SD_BANK_LSB +: 2];
            sa_nxt = 13'(addr_r[`SD_COL_LSB +: `SD_COL_W]);
            state_nxt = S_PRE;
         end
         S_PRE: begin
            // Closed page: every access ends with its bank precharged
            if (sinceAct_r >= 4'(`SD_T_RAS - 1)) begin
               cmd_nxt = `SD_CMD_PRE;
               csN_nxt = ~(4'h1 << csSel);
               ba_nxt = addr_r[`SD_BANK_LSB +: 2];
               waitCnt_nxt = 16'(`SD_T_RP - 2);
               ret_nxt = S_IDLE;
               state_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            if (waitCnt_r == 16'h0) state_nxt = ret_r;
         end
         default: state_nxt = S_INIT;
      endcase
   end

   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         state_r   <= S_INIT;
         ret_r     <= S_INIT;
         waitCnt_r <= 16'(INIT_CYC - 1);
         cmd_r     <= `SD_CMD_NOP;
         csN_r     <= 4'hf;
         ba_r      <= 2'h0;
         sa_r      <= 13'h0;
      end else begin
         state_r   <= state_nxt;
         ret_r     <= ret_nxt;
         waitCnt_r <= waitCnt_nxt;
         cmd_r     <= cmd_nxt;
         csN_r     <= csN_nxt;
         ba_r      <= ba_nxt;
         sa_r      <= sa_nxt;
      end
   end

   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         csIdx_r    <= 2'h0;
         cfgSeen_r  <= 1'b0;
         cfgMode_r  <= 13'h0;
         initDone_r <= 1'b0;
      end else begin
         if (state_r == S_IREF) csIdx_r <= 2'(csIdx_r + 2'h1);
         if (cfgWrite) begin
            cfgSeen_r <= 1'b1;
            cfgMode_r <= cfgMode;
         end
         if (state_r == S_MRS) initDone_r <= 1'b1;
      end
   end

   // Refresh timer only runs once the memory has been brought up
   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         refCnt_r <= 16'(REF_CYC - 1);
         refDue_r <= 1'b0;
      end else if (initDone_r) begin
         refCnt_r <= (refCnt_r == 16'h0) ? 16'(REF_CYC - 1) : 16'(refCnt_r - 16'h1);
         if (refCnt_r == 16'h0) refDue_r <= 1'b1;
         else if (state_r == S_REF) refDue_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         sinceAct_r <= 4'hf;
      end else if (cmd_nxt == `SD_CMD_ACT) begin
         sinceAct_r <= 4'h0;
      end else if (sinceAct_r != 4'hf) begin
         sinceAct_r <= 4'(sinceAct_r + 4'h1);
      end
   end

   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         addr_r     <= '0;
         write_r    <= 1'b0;
         wdata_r    <= '0;
         mask_r     <= '0;
         reqReady_r <= 1'b0;
      end else begin
         if (take) begin
            addr_r  <= reqAddr;
            write_r <= reqWrite;
            wdata_r <= reqWdata;
            mask_r  <= reqMask;
         end
         reqReady_r <= (state_nxt == S_IDLE) && !refDue_r && !take;
      end
   end

   parity_if #(.LANES(LANES)) wrPar ();
   parity_if #(.LANES(LANES)) rdPar ();
   assign wrPar.data     = wdata_r;
   assign wrPar.oddSense = paritySense;
   assign rdPar.data     = dqIn;
   assign rdPar.oddSense = paritySense;
   byte_parity #(.LANES(LANES)) u_wrParity (.bus(wrPar));
   byte_parity #(.LANES(LANES)) u_rdParity (.bus(rdPar));

   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         dqOut_r   <= '0;
         dqOeN_r   <= 1'b1;
         dqm_r     <= '0;
         parOut_r  <= '0;
      end else begin
         dqOeN_r  <= (state_r != S_WR);
         dqm_r    <= (state_r == S_WR) ? mask_r : '0;
         if (state_r == S_WR) begin
            dqOut_r  <= wdata_r;
            parOut_r <= parityEnable ? wrPar.par : '0;
         end
      end
   end

   // Bus is sampled CAS latency cycles after the read leaves the pins
   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         rdPipe_r    <= '0;
         rdValid_r   <= 1'b0;
         rdData_r    <= '0;
         parityErr_r <= 1'b0;
      end else begin
         rdPipe_r  <= {rdPipe_r[CL-1:0], state_r == S_RD};
         rdValid_r <= rdPipe_r[CL];
         if (rdPipe_r[CL]) begin
            rdData_r    <= dqIn;
            parityErr_r <= parityEnable && (rdPar.par != parIn);
         end
      end
   end

   assign memCsN    = csN_r;
   assign {rasN, casN, weN} = cmd_r;
   assign bankSel   = ba_r;
   assign memAddr   = sa_r;
   assign dqOut     = dqOut_r;
   assign dqOeN     = dqOeN_r;
   assign parOeN    = dqOeN_r;
   assign byteMask  = dqm_r;
   assign parOut    = parOut_r;
   assign rdValid   = rdValid_r;
   assign rdData    = rdData_r;
   assign parityErr = parityErr_r;
   assign initDone  = initDone_r;
   assign reqReady  = reqReady_r;

   logic [15:0] nopCnt_r, sinceRef_r;
   logic [3:0]  actGap_r;
   logic        bankOpen_r;
   always_ff @(posedge clock or negedge rstSync_r) begin
      if (!rstSync_r) begin
         nopCnt_r   <= 16'h0;
         sinceRef_r <= 16'h0;
         actGap_r   <= 4'hf;
         bankOpen_r <= 1'b0;
      end else begin
         if (nopCnt_r != 16'(INIT_CYC)) nopCnt_r <= 16'(nopCnt_r + 16'h1);
         // Timer is idle before mode set, so the interval is measured from it
         sinceRef_r <= (cmd_r == `SD_CMD_REF || cmd_r == `SD_CMD_MRS) ? 16'h0 : 16'(sinceRef_r + 16'h1);
         actGap_r <= (cmd_r == `SD_CMD_ACT) ? 4'h0 : ((actGap_r == 4'hf) ? 4'hf : 4'(actGap_r + 4'h1));
         if (cmd_r == `SD_CMD_ACT) bankOpen_r <= 1'b1;
         else if (cmd_r == `SD_CMD_PRE) bankOpen_r <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstSync_r);

   sequence s_pall;
      cmd_r == `SD_CMD_PRE && sa_r[`SD_ALLBANK_BIT] && !initDone_r;
   endsequence
   sequence s_ref;
      cmd_r == `SD_CMD_REF && csN_r == $past(csN_r, 3);
   endsequence

   a_init_nop_only: assert property (cmd_r != `SD_CMD_NOP |-> nopCnt_r >= 16'(INIT_CYC))
      else $error("command issued inside power-up no-op interval");
   a_init_pall_ref: assert property (s_pall |-> ##3 s_ref)
      else $error("precharge-all not followed by refresh on same select");
   a_mrs_after_cfg: assert property (cmd_r == `SD_CMD_MRS |-> cfgSeen_r)
      else $error("mode set without configuration write");
   a_done_from_mrs: assert property ($rose(initDone_r) |-> cmd_r == `SD_CMD_MRS)
      else $error("init flag rose without mode set");
   a_mask_read_clear: assert property (cmd_r == `SD_CMD_READ |-> byteMask == '0 ##1 byteMask == '0)
      else $error("byte mask active around a read");
   a_act_to_rw: assert property ((cmd_r == `SD_CMD_READ || cmd_r == `SD_CMD_WRITE) |-> actGap_r >= 4'h2)
      else $error("read or write too soon after activate");
   a_wr_then_pre: assert property (cmd_r == `SD_CMD_WRITE |=> cmd_r != `SD_CMD_PRE || !dqOeN)
      else $error("precharge overlaps write data");
   a_act_spacing: assert property (cmd_r == `SD_CMD_ACT |-> actGap_r >= 4'h4)
      else $error("activates closer than five cycles");
   a_par_disabled: assert property (cmd_r == `SD_CMD_WRITE && !$past(parityEnable) |-> parOut == '0)
      else $error("parity driven while disabled");
   a_par_sense: assert property (cmd_r == `SD_CMD_WRITE && $past(parityEnable)
                                 |-> (^{dqOut[7:0], parOut[0]}) == $past(paritySense))
      else $error("write parity sense wrong");
   a_ref_period: assert property (initDone_r |-> sinceRef_r < 16'(REF_CYC + 40))
      else $error("refresh interval overrun");
   a_bank_closed: assert property (cmd_r == `SD_CMD_ACT |-> !bankOpen_r)
      else $error("activate while a bank is open");
endmodule

/* File: pkg/parity_if.sv */
// Byte parity bundle between the controller and its parity units.
// Assumes one parity bit per data byte.
`timescale 1ns/10ps
interface parity_if #(parameter int LANES = 8);
   logic [LANES*8-1:0] data;
   logic               oddSense;
   logic [LANES-1:0]   par;
   modport calc (input data, input oddSense, output par);
   modport user (output data, output oddSense, input par);
endinterface

/* File: pkg/sdram_ctrl_map.svh */
// Constants of the memory initialisation and timing controller.
// Assumes a 100 MHz controller clock; every timing count but SD_INIT_US (in microseconds) is in controller cycles.
// What this block does
// - Only no-ops for 200 us after reset
// - Per chip select: precharge-all, then auto-refresh
// - Mode set only after config write
// - Mode set raises init-complete flag
// - Byte masks act on write data only
// - Activate to read/write at least 3 cycles
// - Last write data to precharge 1 cycle
// - Activates spaced at least 5 cycles
// - Data path is 64 bits wide
// - Parity enable: generate on write, check read
// - Parity sense picks odd or even
`ifndef SDRAM_CTRL_MAP_SVH
`define SDRAM_CTRL_MAP_SVH

`define SD_CLK_MHZ   100
`define SD_INIT_US   200
`define SD_INIT_CYC  (`SD_INIT_US * `SD_CLK_MHZ)
`define SD_T_RCD     3
`define SD_T_RWL     1
`define SD_T_RRD     5
`define SD_T_RP      3
`define SD_T_RC      9
`define SD_T_RAS     6
`define SD_T_MRD     2
`define SD_CAS_LAT   3
`define SD_REF_CYC   780

`define SD_CMD_NOP   3'h7
`define SD_CMD_ACT   3'h3
`define SD_CMD_READ  3'h5
`define SD_CMD_WRITE 3'h4
`define SD_CMD_PRE   3'h2
`define SD_CMD_REF   3'h1
`define SD_CMD_MRS   3'h0

`define SD_ALLBANK_BIT 10
`define SD_COL_LSB   0
`define SD_COL_W     9
`define SD_BANK_LSB  9
`define SD_ROW_LSB   11
`define SD_ROW_W     13
`define SD_CS_LSB    24
`define SD_ADDR_W    26

`endif

/* File: pkg/sdram_pkg.sv */
// Types shared by the memory controller modules.
// Assumes the constants header is compiled alongside.
package sdram_pkg;
   typedef enum logic [3:0] {
      S_INIT, S_IPALL, S_IREF, S_CFG, S_MRS, S_IDLE, S_REF,
      S_ACT, S_RD, S_WR, S_PRE, S_WAIT
   } state_t;
   typedef logic [2:0] cmd_t;
endpackage

/* File: verif/sdram_mem_model.sv */
// Behavioural memory chips behind the controller's pins.
// Assumes CAS latency 3, burst of one, commands taken on the rising edge.
`timescale 1ns/10ps
`include "sdram_ctrl_map.svh"
module sdram_mem_model (
   input  wire logic        clock,
   input  wire logic [3:0]  memCsN,
   input  wire logic        rasN,
   input  wire logic        casN,
   input  wire logic        weN,
   input  wire logic [1:0]  bankSel,
   input  wire logic [12:0] memAddr,
   input  wire logic [63:0] dqOut,
   input  wire logic        dqOeN,
   input  wire logic [7:0]  byteMask,
   input  wire logic [7:0]  parOut,
   input  wire logic        badPar,
   output logic      [63:0] dqIn,
   output logic      [7:0]  parIn
);
   logic [71:0] mem [logic [25:0]];
   logic [12:0] openRow [16];
   logic [71:0] word;
   logic [71:0] pend;
   logic [25:0] key;
   logic [1:0]  cs;
   logic [2:0]  c;
   int          rdCnt = 0;
   initial begin
      dqIn = 64'h0;
      parIn = 8'h0;
   end
   always @(posedge clock) begin
      cs = !memCsN[0] ? 2'h0 : !memCsN[1] ? 2'h1 : !memCsN[2] ? 2'h2 : 2'h3;
      c = (memCsN == 4'hf) ? `SD_CMD_NOP : {rasN, casN, weN};
      key = {cs, bankSel, openRow[{cs, bankSel}], memAddr[8:0]};
      word = mem.exists(key) ? mem[key] : 72'h0;
      // Released bus inverts each cycle, so the last word shows again every other cycle
      // Word stands for exactly the CAS latency sampling edge
      if (rdCnt == 2) begin
         dqIn <= pend[63:0];
         parIn <= pend[71:64] ^ {7'h0, badPar};
         rdCnt <= 3;
      end else begin
         dqIn <= ~dqIn;
         parIn <= ~parIn;
         rdCnt <= (rdCnt == 1) ? 2 : 0;
      end
      if (c == `SD_CMD_ACT) openRow[{cs, bankSel}] <= memAddr;
      if (c == `SD_CMD_WRITE && !dqOeN) begin
         for (int i = 0; i < 8; i++) begin
            if (!byteMask[i]) begin
               word[8*i+:8] = dqOut[8*i+:8];
               word[64+i] = parOut[i];
            end
         end
         mem[key] = word;
      end
      if (c == `SD_CMD_READ) begin
         pend <= word;
         rdCnt <= 1;
      end
   end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the memory controller with a memory model.
// Assumes short init and refresh counts through the top's parameters.
`timescale 1ns/10ps
`include "sdram_ctrl_map.svh"
module testbench;
   import sdram_pkg::*;
   localparam int INIT_CYC = 50;
   localparam int REF_CYC  = 200;
   logic        clock, rst_n, reqValid, reqReady, reqWrite, rdValid, parityErr, cfgWrite;
   logic        parityEnable, paritySense, initDone, rasN, casN, weN, dqOeN, parOeN, badPar;
   logic [25:0] reqAddr;
   logic [63:0] reqWdata, rdData, dqOut, dqIn, wData;
   logic [7:0]  reqMask, byteMask, parOut, parIn, wMask;
   logic [12:0] cfgMode, memAddr, modeW;
   logic [3:0]  memCsN;
   logic [1:0]  bankSel;
   logic [63:0] mirror [logic [25:0]];
   logic [25:0] adr [8];
   int          error_cnt = 0, compares = 0, cyc = 0, relCyc = 0, nInit = 0, lastRef = 0;
   int          lastAct [16], actCyc = -100, lastWr = -100, seed = 32'h5a39;
   logic [3:0]  actIdx = 4'h0;
   bit          mrsSeen = 0, cfgSeen = 0;

   sdram_init_and_timing_ctrl #(.INIT_CYC(INIT_CYC), .REF_CYC(REF_CYC)) sdram_init_and_timing_ctrl_i (
      .clock(clock), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqWdata(reqWdata), .reqMask(reqMask), .rdValid(rdValid), .rdData(rdData),
      .parityErr(parityErr), .cfgWrite(cfgWrite), .cfgMode(cfgMode), .parityEnable(parityEnable),
      .paritySense(paritySense), .initDone(initDone), .memCsN(memCsN), .rasN(rasN), .casN(casN),
      .weN(weN), .bankSel(bankSel), .memAddr(memAddr), .dqOut(dqOut), .dqIn(dqIn), .dqOeN(dqOeN),
      .byteMask(byteMask), .parOut(parOut), .parIn(parIn), .parOeN(parOeN));
   sdram_mem_model sdram_mem_model_i (
      .clock(clock), .memCsN(memCsN), .rasN(rasN), .casN(casN), .weN(weN), .bankSel(bankSel),
      .memAddr(memAddr), .dqOut(dqOut), .dqOeN(dqOeN), .byteMask(byteMask), .parOut(parOut),
      .badPar(badPar), .dqIn(dqIn), .parIn(parIn));

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait; a hang ends the run with the report
   // Sampled at the falling edge, where outputs have settled
   task automatic waitHi(ref logic sig, input string what);
      for (int n = 0; n < 400; n++) begin
         if (sig === 1'b1) return;
         @(negedge clock);
      end
      error_cnt++;
      $display("Error timeout %s expected 1 seen %b", what, sig);
      print_verdict;
   endtask
   function automatic logic [7:0] par8(input logic [63:0] d, input logic s);
      for (int i = 0; i < 8; i++) par8[i] = ^d[8*i+:8] ^ s;
   endfunction
   function automatic logic [3:0] idxOf(input logic [3:0] n, input logic [1:0] b);
      idxOf = {(!n[0] ? 2'h0 : !n[1] ? 2'h1 : !n[2] ? 2'h2 : 2'h3), b};
   endfunction
   task automatic access(input logic wr, input logic [25:0] a, input logic [63:0] d,
                         input logic [7:0] m, input logic expErr);
      logic [63:0] old;
      @(negedge clock);
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = a;
      reqWdata = d;
      reqMask = m;
      waitHi(reqReady, "reqReady");
      // Updated only at take, so the previous write's pins still match
      wData = d;
      wMask = m;
      @(negedge clock);
      reqValid = 1'b0;
      if (wr) begin
         old = mirror.exists(a) ? mirror[a] : 64'h0;
         for (int i = 0; i < 8; i++) if (!m[i]) old[8*i+:8] = d[8*i+:8];
         mirror[a] = old;
      end else begin
         waitHi(rdValid, "rdValid");
         chk("rdData", mirror[a], rdData);
         chk("parityErr", expErr, parityErr);
      end
   endtask

   // Pin monitor: command order, spacing and write-cycle contents
   always @(posedge clock) begin
      cmd_t c;
      logic [3:0] ix;
      cyc++;
      c = (memCsN == 4'hf) ? `SD_CMD_NOP : {rasN, casN, weN};
      ix = idxOf(memCsN, bankSel);
      if (!rst_n) relCyc = cyc;
      else begin
         if (c != `SD_CMD_NOP && nInit < 8) begin
            if (nInit == 0) chk("init wait", 1, (cyc - relCyc) >= INIT_CYC);
            chk("init cmd", (nInit % 2) ? `SD_CMD_REF : `SD_CMD_PRE, c);
            chk("init cs", 4'(~(4'h1 << (nInit / 2))), memCsN);
            if (nInit % 2 == 0) chk("all banks", 1, memAddr[`SD_ALLBANK_BIT]);
            nInit++;
         end
         chk("initDone", mrsSeen || c == `SD_CMD_MRS, initDone);
         chk("byteMask", c == `SD_CMD_WRITE ? wMask : 8'h0, byteMask);
         chk("dqOeN", c != `SD_CMD_WRITE, dqOeN);
         chk("parOeN", c != `SD_CMD_WRITE, parOeN);
         if (c == `SD_CMD_MRS) begin
            chk("mode after cfg", 1, cfgSeen);
            chk("mode word", modeW, memAddr);
            mrsSeen = 1;
            lastRef = cyc;
         end
         if (c == `SD_CMD_WRITE || c == `SD_CMD_READ)
            chk("act to cas", 1, cyc - lastAct[ix] >= `SD_T_RCD);
         if (c == `SD_CMD_WRITE) begin
            chk("dqOut", wData, dqOut);
            if (parityEnable) chk("parOut", par8(wData, paritySense), parOut);
            lastWr = cyc;
         end
         if (c == `SD_CMD_PRE && cyc - lastWr < 10) chk("wr to pre", 1, cyc - lastWr > `SD_T_RWL);
         if (c == `SD_CMD_ACT) begin
            if (ix != actIdx) chk("act to act", 1, cyc - actCyc >= `SD_T_RRD);
            lastAct[ix] = cyc;
            actCyc = cyc;
            actIdx = ix;
         end
         if (c == `SD_CMD_REF && mrsSeen) chk("refresh gap", 1, cyc - lastRef <= REF_CYC + 30);
         if (c == `SD_CMD_REF || (mrsSeen && cyc - lastRef > REF_CYC + 30)) begin
            if (c != `SD_CMD_REF) chk("refresh missing", 1, 0);
            lastRef = cyc;
         end
      end
   end

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      logic [25:0] a;
      foreach (lastAct[i]) lastAct[i] = -100;
      {rst_n, reqValid, reqWrite, cfgWrite, badPar} = 5'h0;
      {reqAddr, reqWdata, reqMask, cfgMode, modeW, wData, wMask} = '0;
      parityEnable = 1'b1;
      paritySense = 1'b1;
      repeat (10) @(negedge clock);
      chk("reset cs", 4'hf, memCsN);
      chk("reset cmd", `SD_CMD_NOP, {rasN, casN, weN});
      chk("reset oe", 2'h3, {dqOeN, parOeN});
      rst_n = 1'b1;
      repeat (INIT_CYC + 150) @(negedge clock);
      chk("init count", 8, nInit);
      chk("no flag early", 0, initDone);
      modeW = $random(seed);
      cfgMode = modeW;
      cfgWrite = 1'b1;
      cfgSeen = 1;
      @(negedge clock);
      cfgWrite = 1'b0;
      waitHi(initDone, "initDone");
      $display("Test init done");
      foreach (adr[i]) begin
         adr[i] = $random(seed);
         access(1'b1, adr[i], {$random(seed), $random(seed)}, 8'h0, 1'b0);
      end
      // Full mask must leave the word untouched
      access(1'b1, adr[0], 64'h0, 8'hff, 1'b0);
      access(1'b0, adr[0], 64'h0, 8'h0, 1'b0);
      for (int k = 0; k < 40; k++) begin
         a = adr[$random(seed) & 7];
         access($random(seed) & 1, a, {$random(seed), $random(seed)}, $random(seed), 1'b0);
      end
      $display("Test random traffic done");
      for (int pm = 0; pm < 8; pm++) begin
         @(negedge clock);
         parityEnable = pm[2];
         paritySense = pm[1];
         badPar = pm[0];
         access(1'b1, adr[pm], {$random(seed), $random(seed)}, 8'h0, 1'b0);
         access(1'b0, adr[pm], 64'h0, 8'h0, pm[2] & pm[0]);
      end
      $display("Test parity done");
      repeat (3 * REF_CYC) @(negedge clock);
      $display("Test refresh done");
      print_verdict;
   end
endmodule
